/* File: shared/adc_regs_defines.svh */
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH

// serial frame geometry
`define ADC_FRAME_BITS      16
`define ADC_PAYLOAD_BITS    14
`define ADC_RESULT_BITS     12
`define ADC_RESULT_PAD      4'h0
`define ADC_PAYLOAD_PAD     2'h0
`define ADC_LAST_BIT_INDEX  5'h0F
`define ADC_FULL_COUNT      5'h10

// write address codes
`define ADC_WADDR_NONE      2'h0
`define ADC_WADDR_TEST      2'h1
`define ADC_WADDR_CAL       2'h2
`define ADC_WADDR_CONTROL   2'h3

// read select codes
`define ADC_RSEL_RESULT     2'h0
`define ADC_RSEL_TEST       2'h1
`define ADC_RSEL_CAL        2'h2
`define ADC_RSEL_STATUS     2'h3

// control field positions
`define ADC_CTL_RSEL_LO_POS 6
`define ADC_CTL_RSEL_HI_POS 7

// reset values
`define ADC_CONTROL_RESET   14'h0000
`define ADC_TEST_RESET      14'h0000
`define ADC_CAL_RESET       14'h0000
`define ADC_WORD_RESET      16'h0000

`endif

/* File: shared/adc_regs_pkg.sv */
package adc_regs_pkg;

  typedef struct packed {
    logic [3:0] reserved;
    logic       power_mgmt_hi;
    logic       power_mgmt_lo;
    logic       read_select_hi;
    logic       read_select_lo;
    logic       iface_mode_bit;
    logic       conversion_start_bit;
    logic       calibration_mode_bit;
    logic       calibration_select_hi;
    logic       calibration_select_lo;
    logic       calibration_start_bit;
  } control_word_s;

  typedef struct packed {
    logic        write_addr_hi;
    logic        write_addr_lo;
    logic [13:0] payload;
  } write_frame_s;

  typedef enum logic [1:0] {
    FRAME_IDLE,
    FRAME_SHIFT,
    FRAME_HOLD
  } frame_state_e;

endpackage

/* File: logic/serial_frame_shifter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_defines.svh"

module serial_frame_shifter (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     sclk,
  input  wire logic                     sync_n,
  input  wire logic                     din,
  input  wire logic [15:0]              load_word,
  output logic                          frame_active,
  output logic                          word_done,
  output adc_regs_pkg::write_frame_s    rx_frame,
  output logic                          tx_bit
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 3'h4;
      pin_sync <= 3'h4;
      pin_prev <= 3'h4;
    end else begin
      pin_meta <= {sync_n, sclk, din};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;

  assign sclk_rise = pin_sync[1] & ~pin_prev[1];
  assign sclk_fall = ~pin_sync[1] & pin_prev[1];
  assign sync_fall = ~pin_sync[2] & pin_prev[2];
  assign sync_rise = pin_sync[2] & ~pin_prev[2];

  // ****************************************
  // frame sequencing
  // ****************************************
  adc_regs_pkg::frame_state_e state;
  logic [4:0]                 bit_count;
  logic [15:0]                rx_shift;
  logic [15:0]                tx_shift;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= adc_regs_pkg::FRAME_IDLE;
    end else begin
      unique case (state)
        adc_regs_pkg::FRAME_IDLE: begin
          if (sync_fall) begin
            state <= adc_regs_pkg::FRAME_SHIFT;
          end
        end
        adc_regs_pkg::FRAME_SHIFT: begin
          if (sync_rise) begin
            state <= adc_regs_pkg::FRAME_IDLE;
          end else if (sclk_rise && bit_count == `ADC_LAST_BIT_INDEX) begin
            state <= adc_regs_pkg::FRAME_HOLD;
          end
        end
        adc_regs_pkg::FRAME_HOLD: begin
          if (sync_rise) begin
            state <= adc_regs_pkg::FRAME_IDLE;
          end
        end
      endcase
    end
  end

  // msb first in both directions
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_count <= 5'h00;
      rx_shift  <= `ADC_WORD_RESET;
    end else if (sync_fall) begin
      bit_count <= 5'h00;
    end else if (state == adc_regs_pkg::FRAME_SHIFT && sclk_rise) begin
      bit_count <= bit_count + 5'h01;
      rx_shift  <= {rx_shift[14:0], pin_sync[0]};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_shift <= `ADC_WORD_RESET;
    end else if (sync_fall) begin
      tx_shift <= load_word;
    end else if (state != adc_regs_pkg::FRAME_IDLE && sclk_fall) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // only a full word is ever handed over
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_done <= 1'b0;
      rx_frame  <= `ADC_WORD_RESET;
    end else begin
      word_done <= 1'b0;
      if (state == adc_regs_pkg::FRAME_SHIFT && sclk_rise && !sync_rise
          && bit_count == `ADC_LAST_BIT_INDEX) begin
        word_done <= 1'b1;
        rx_frame  <= {rx_shift[14:0], pin_sync[0]};
      end
    end
  end

  assign frame_active = (state != adc_regs_pkg::FRAME_IDLE);
  assign tx_bit       = tx_shift[15];

endmodule
`default_nettype wire

/* File: logic/adc_register_addressing.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_defines.svh"

module adc_register_addressing #(
  parameter int CAL_DEPTH = 4
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        sclk,
  input  wire logic                        sync_n,
  input  wire logic                        din,
  input  wire logic [11:0]                 conv_result,
  input  wire logic [15:0]                 status_word,
  input  wire logic                        conv_done,
  input  wire logic                        cal_done,
  output logic                             dout,
  output logic                             din_out,
  output logic                             din_oe_n,
  output adc_regs_pkg::control_word_s      control_word
);

  // ****************************************
  // serial frame engine
  // ****************************************
  logic                       frame_active;
  logic                       word_done;
  adc_regs_pkg::write_frame_s rx_frame;
  logic                       tx_bit;
  logic [15:0]                load_word;

  serial_frame_shifter u_shifter (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .sclk         (sclk),
    .sync_n       (sync_n),
    .din          (din),
    .load_word    (load_word),
    .frame_active (frame_active),
    .word_done    (word_done),
    .rx_frame     (rx_frame),
    .tx_bit       (tx_bit)
  );

  // ****************************************
  // write decode
  // ****************************************
  logic [1:0] write_addr;
  logic       test_write;
  logic       cal_write;
  logic       ctrl_write;

  assign write_addr = {rx_frame.write_addr_hi, rx_frame.write_addr_lo};
  // a held-low input gives code 00 and is dropped
  assign test_write = word_done && write_addr == `ADC_WADDR_TEST;
  assign cal_write  = word_done && write_addr == `ADC_WADDR_CAL;
  assign ctrl_write = word_done && write_addr == `ADC_WADDR_CONTROL;

  // ****************************************
  // registers
  // ****************************************
  logic [13:0] test_reg;
  logic [13:0] cal_regs [CAL_DEPTH];
  logic [1:0]  cal_index;
  logic [1:0]  read_select;

  assign cal_index   = {control_word.calibration_select_hi, control_word.calibration_select_lo};
  assign read_select = {control_word.read_select_hi, control_word.read_select_lo};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      test_reg <= `ADC_TEST_RESET;
    end else if (test_write) begin
      test_reg <= rx_frame.payload;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CAL_DEPTH; gi++) begin : g_cal
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cal_regs[gi] <= `ADC_CAL_RESET;
        end else if (cal_write && cal_index == 2'(gi)) begin
          cal_regs[gi] <= rx_frame.payload;
        end
      end
    end
  endgenerate

  // set by write wins over hardware clears
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_word <= `ADC_CONTROL_RESET;
    end else if (ctrl_write) begin
      control_word <= rx_frame.payload;
    end else begin
      if (conv_done) begin
        control_word.conversion_start_bit <= 1'b0;
      end
      if (cal_done) begin
        control_word.calibration_start_bit <= 1'b0;
      end
      if (word_done) begin
        control_word.iface_mode_bit <= 1'b0;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    unique case (read_select)
      `ADC_RSEL_RESULT: load_word = {`ADC_RESULT_PAD, conv_result};
      `ADC_RSEL_TEST:   load_word = {`ADC_PAYLOAD_PAD, test_reg};
      `ADC_RSEL_CAL:    load_word = {`ADC_PAYLOAD_PAD, cal_regs[cal_index]};
      `ADC_RSEL_STATUS: load_word = status_word;
    endcase
  end

  // dual-use data pin only drives in interface mode 1
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dout     <= 1'b0;
      din_out  <= 1'b0;
      din_oe_n <= 1'b1;
    end else begin
      dout     <= tx_bit;
      din_out  <= tx_bit;
      din_oe_n <= ~(frame_active && control_word.iface_mode_bit);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_PARTIAL_NO_WRITE: assert property (!word_done |=> $stable(test_reg))
    else $error("test register changed without a full frame");

  AST_ADDR00_DISCARD: assert property (
    word_done && write_addr == `ADC_WADDR_NONE |=> $stable(test_reg) && $stable(read_select))
    else $error("address 00 frame modified a register");

  AST_TEST_LOAD: assert property (
    word_done && write_addr == `ADC_WADDR_TEST |=> test_reg == $past(rx_frame.payload))
    else $error("test register not loaded");

  AST_CTRL_LOAD: assert property (
    ctrl_write |=> read_select == $past(rx_frame.payload[`ADC_CTL_RSEL_HI_POS:`ADC_CTL_RSEL_LO_POS]))
    else $error("read select not taken from control bits 7:6");

  AST_SELECT_PERSIST: assert property (!ctrl_write |=> $stable(read_select))
    else $error("read select changed without control write");

  AST_RESULT_PAD: assert property (
    read_select == `ADC_RSEL_RESULT |-> load_word == {4'h0, conv_result})
    else $error("result read lacks four leading zeros");

  AST_STATUS_READ: assert property (
    read_select == `ADC_RSEL_STATUS |-> load_word == status_word)
    else $error("status select returned wrong data");

  AST_CONV_CLEAR: assert property (
    conv_done && !ctrl_write |=> !control_word.conversion_start_bit)
    else $error("conversion start bit not cleared");

  AST_CAL_CLEAR: assert property (
    cal_done && !ctrl_write |=> !control_word.calibration_start_bit)
    else $error("calibration start bit not cleared");

  AST_MODE_CLEAR: assert property (
    word_done && !ctrl_write |=> !control_word.iface_mode_bit ##1 din_oe_n)
    else $error("interface mode bit survived a read");

  COVER_CTRL_WRITE: cover property (ctrl_write ##1 read_select == `ADC_RSEL_STATUS);
  COVER_CAL_WRITE:  cover property (cal_write);
  COVER_ABORT:      cover property (frame_active ##1 !frame_active && !$past(word_done));

endmodule
`default_nettype wire

/* File: tb/serial_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host end of the serial register port
// ****************************************
module serial_host (
  output logic      sclk,
  output logic      sync_n,
  output logic      din,
  input  wire logic dout
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end

  // one frame, nbits rising edges, read word shifted in alongside
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    sync_n = 1'b0;
    #62.5;
    for (int i = 0; i < nbits; i++) begin
      din = w[15 - i];
      #62.5;
      sclk = 1'b1;
      rd = {rd[14:0], dout};
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    sync_n = 1'b1;
    din = ~din;
    #125.0;
  endtask
endmodule
`default_nettype wire

/* File: tb/adc_register_addressing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_register_addressing_tb;
  logic                        sys_clk;
  logic                        rst;
  logic                        sclk;
  logic                        sync_n;
  logic                        host_din;
  logic                        conv_done;
  logic                        cal_done;
  logic                        dout;
  logic                        din_out;
  logic                        din_oe_n;
  logic [11:0]                 conv_result;
  logic [15:0]                 status_word;
  logic [15:0]                 rd;
  logic [15:0]                 ctl_seen;
  logic [15:0]                 din_rd;
  logic                        oe_seen;
  adc_regs_pkg::control_word_s control_word;
  int                          n_mismatch;
  int                          comparisons;
  // shared data pin: device drives while its enable is low
  wire logic                   din_pin = din_oe_n ? host_din : din_out;

  adc_register_addressing #(.CAL_DEPTH(4)) dut (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .sclk         (sclk),
    .sync_n       (sync_n),
    .din          (din_pin),
    .conv_result  (conv_result),
    .status_word  (status_word),
    .conv_done    (conv_done),
    .cal_done     (cal_done),
    .dout         (dout),
    .din_out      (din_out),
    .din_oe_n     (din_oe_n),
    .control_word (control_word)
  );

  serial_host host (
    .sclk   (sclk),
    .sync_n (sync_n),
    .din    (host_din),
    .dout   (dout)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  assign ctl_seen = {2'h0, control_word};

  // data pin as the host sees it at each sclk rise
  always @(posedge sclk) begin
    din_rd <= {din_rd[14:0], din_pin};
  end

  // whether the device ever drove the data pin
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oe_seen <= 1'b0;
    end else if (!din_oe_n) begin
      oe_seen <= 1'b1;
    end
  end

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [15:0] w);
    host.xfer(w, 16, rd);
  endtask

  // read frame carries address 00, so nothing is written
  task automatic rd_chk(input logic [15:0] exp);
    host.xfer(16'h0000, 16, rd);
    check(rd, exp);
  endtask

  task automatic pulse(input logic cal);
    @(negedge sys_clk);
    conv_done = ~cal;
    cal_done = cal;
    @(negedge sys_clk);
    conv_done = 1'b0;
    cal_done = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst = 1'b1;
    conv_done = 1'b0;
    cal_done = 1'b0;
    conv_result = 12'hABC;
    status_word = 16'h5A3C;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    check(ctl_seen, 16'h0000);
    rd_chk(16'h0ABC);
    send(16'hC040);
    check(ctl_seen, 16'h0040);
    send(16'h41A5);
    rd_chk(16'h01A5);
    host.xfer(16'h7FFF, 12, rd);
    rd_chk(16'h01A5);
    host.xfer(16'h3FFF, 16, rd);
    check(rd, 16'h01A5);
    rd_chk(16'h01A5);
    send(16'hC082);
    send(16'hA222);
    rd_chk(16'h2222);
    send(16'hC0C0);
    rd_chk(16'h5A3C);
    send(16'hC010);
    check(ctl_seen, 16'h0010);
    pulse(1'b0);
    check(ctl_seen, 16'h0000);
    send(16'hC001);
    check(ctl_seen, 16'h0001);
    pulse(1'b1);
    check(ctl_seen, 16'h0000);
    check({15'h0000, oe_seen}, 16'h0000);
    send(16'hC020);
    check(ctl_seen, 16'h0020);
    rd_chk(16'h0ABC);
    check(din_rd, 16'h0ABC);
    check({15'h0000, oe_seen}, 16'h0001);
    check(ctl_seen, 16'h0000);
    rd_chk(16'h0ABC);
    check(din_rd, 16'h0000);
    final_report();
  end

  initial begin
    #150000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
